// ==== core/vms_pkg.sv ====
// Package for the virtualization mode sequencer: states, commands, widths.
// Assumes one core clock domain and a decoded instruction/event stream.
package vms_pkg;

  // Operating state of one logical processor
  typedef enum logic [1:0] {
    VMS_OUTSIDE,
    VMS_ROOT,
    VMS_NONROOT
  } vms_state_t;

  // Commands retired by the core toward the sequencer
  typedef enum logic [2:0] {
    VMS_CMD_NONE,
    VMS_CMD_ENTER,
    VMS_CMD_LEAVE,
    VMS_CMD_FIRST_ENTRY,
    VMS_CMD_REPEAT_ENTRY,
    VMS_CMD_MONITOR_CALL
  } vms_cmd_t;

  localparam int unsigned VMS_ADDR_W     = 64;
  localparam int unsigned VMS_CTX_W      = 16;
  localparam int unsigned VMS_CTRL_W     = 32;
  localparam int unsigned VMS_ENABLE_BIT = 13;
  localparam int unsigned VMS_PRIV_W     = 2;

  // Exit cause codes reported with each guest exit
  localparam logic [2:0] VMS_EXIT_NONE  = 3'h0;
  localparam logic [2:0] VMS_EXIT_CALL  = 3'h1;
  localparam logic [2:0] VMS_EXIT_TRAP  = 3'h2;
  localparam logic [2:0] VMS_EXIT_EVENT = 3'h3;
  localparam logic [2:0] VMS_EXIT_INIT  = 3'h4;

  // One retired instruction or command from the core
  typedef struct packed {
    logic                   valid;
    vms_cmd_t               cmd;
    logic [VMS_CTX_W-1:0]   ctx;
    logic                   trap_sel;
    logic [VMS_PRIV_W-1:0]  priv;
  } vms_req_t;

  // Redirect issued on a guest exit
  typedef struct packed {
    logic                   valid;
    logic [VMS_ADDR_W-1:0]  target;
    logic [2:0]             cause;
  } vms_redir_t;

endpackage

// ==== core/vms_sequencer.sv ====
// Virtualization mode sequencer: tracks outside, root and non-root state.
// Assumes requests and events are synchronous to mclk_in, one per cycle.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - Separate root and non-root sub-states exist
// - Enter instruction moves outside to root
// - Guest entry in root moves to non-root
// - Guest exit returns non-root to root
// - Every exit redirects to monitor entry point
// - Monitor call, trapped ops, events cause exit
// - No software-visible non-root indication
// - Root behaves as outside, plus extras
// - Leave instruction exits virtualization entirely
// - One guest context at a time
// - Restrictions apply at every privilege level
// - Enter outside with enable bit clear faults
// - Soft init held in root, exits in non-root
module vms_sequencer
  import vms_pkg::*;
(
  input  wire logic                  mclk_in,
  input  wire logic                  rstn_in,
  input  wire vms_req_t              req_in,
  input  wire logic [VMS_CTRL_W-1:0] ctrl_reg_in,
  input  wire logic [VMS_ADDR_W-1:0] entry_point_in,
  input  wire logic                  exit_event_in,
  input  wire logic                  soft_init_in,
  output var  vms_state_t            state_out,
  output logic                       virt_instr_en_out,
  output logic                       ctrl_restrict_out,
  output logic                       in_virt_op_out,
  output logic                       ud_fault_out,
  output logic                       init_held_out,
  output logic                       init_deliver_out,
  output var  vms_redir_t            redir_out,
  output logic [VMS_CTX_W-1:0]       guest_ctx_out,
  output logic                       guest_restrict_out
);

  vms_state_t            state;
  vms_state_t            next_state;
  logic                  req_valid;
  logic                  is_entry;
  logic                  do_exit;
  logic [2:0]            next_cause;
  logic                  virt_en;

  assign req_valid = req_in.valid;
  assign virt_en   = ctrl_reg_in[VMS_ENABLE_BIT];
  assign is_entry  = req_valid && (req_in.cmd == VMS_CMD_FIRST_ENTRY ||
                                   req_in.cmd == VMS_CMD_REPEAT_ENTRY);

  // Exit cause in non-root; privilege level deliberately ignored
  always_comb begin
    do_exit    = 1'b0;
    next_cause = VMS_EXIT_NONE;
    if (state == VMS_NONROOT) begin
      if (soft_init_in) begin
        do_exit    = 1'b1;
        next_cause = VMS_EXIT_INIT;
      end else if (exit_event_in) begin
        do_exit    = 1'b1;
        next_cause = VMS_EXIT_EVENT;
      end else if (req_valid && req_in.cmd == VMS_CMD_MONITOR_CALL) begin
        do_exit    = 1'b1;
        next_cause = VMS_EXIT_CALL;
      end else if (req_valid && req_in.trap_sel) begin
        do_exit    = 1'b1;
        next_cause = VMS_EXIT_TRAP;
      end
    end
  end

  // Next-state selection
  always_comb begin
    next_state = state;
    unique case (state)
      VMS_OUTSIDE: begin
        if (req_valid && req_in.cmd == VMS_CMD_ENTER && virt_en) begin
          next_state = VMS_ROOT;
        end
      end
      VMS_ROOT: begin
        if (req_valid && req_in.cmd == VMS_CMD_LEAVE) begin
          next_state = VMS_OUTSIDE;
        end else if (is_entry) begin
          next_state = VMS_NONROOT;
        end
      end
      VMS_NONROOT: begin
        if (do_exit) begin
          next_state = VMS_ROOT;
        end
      end
      default: next_state = VMS_OUTSIDE;
    endcase
  end

  // State register, outside after reset
  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      state <= VMS_OUTSIDE;
    end else begin
      state <= next_state;
    end
  end

  // Enter outside with enable bit clear raises the opcode fault
  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      ud_fault_out <= 1'b0;
    end else begin
      ud_fault_out <= req_valid && req_in.cmd == VMS_CMD_ENTER && !virt_en
                      && state == VMS_OUTSIDE;
    end
  end

  // Redirect to the monitor's entry point, not the guest stream
  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      redir_out <= '0;
    end else begin
      redir_out.valid  <= do_exit;
      redir_out.cause  <= next_cause;
      if (do_exit) begin
        redir_out.target <= entry_point_in;
      end
    end
  end

  // Single guest context latched per entry
  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      guest_ctx_out <= '0;
    end else if (state == VMS_ROOT && is_entry) begin
      guest_ctx_out <= req_in.ctx;
    end
  end

  // Soft init: held in root, delivered normally outside
  always_ff @(posedge mclk_in) begin
    if (!rstn_in) begin
      init_held_out    <= 1'b0;
      init_deliver_out <= 1'b0;
    end else begin
      init_held_out    <= soft_init_in && state == VMS_ROOT;
      init_deliver_out <= soft_init_in && state == VMS_OUTSIDE;
    end
  end

  // Root keeps ordinary behaviour plus two extras
  assign virt_instr_en_out  = (state != VMS_OUTSIDE);
  assign ctrl_restrict_out  = (state != VMS_OUTSIDE);
  // Only this flag reaches software; it is the same in root and non-root
  assign in_virt_op_out     = (state != VMS_OUTSIDE);
  // Internal only, never routed to software-readable state
  assign guest_restrict_out = (state == VMS_NONROOT);
  assign state_out          = state;

  a_enter_to_root: assert property (@(posedge mclk_in) disable iff (!rstn_in)
    state == VMS_OUTSIDE && req_valid && req_in.cmd == VMS_CMD_ENTER && virt_en
    |=> state == VMS_ROOT) else $error("enter did not reach root");
  a_entry_to_guest: assert property (@(posedge mclk_in) disable iff (!rstn_in)
    state == VMS_ROOT && is_entry && req_in.cmd != VMS_CMD_LEAVE
    |=> state == VMS_NONROOT && guest_ctx_out == $past(req_in.ctx))
    else $error("guest entry failed");
  a_exit_to_root: assert property (@(posedge mclk_in) disable iff (!rstn_in)
    state == VMS_NONROOT && exit_event_in |=> state == VMS_ROOT && redir_out.valid)
    else $error("exit did not return to root");
  a_exit_redirect: assert property (@(posedge mclk_in) disable iff (!rstn_in)
    redir_out.valid |-> $past(state) == VMS_NONROOT && state == VMS_ROOT
    && redir_out.target == $past(entry_point_in)) else $error("bad redirect");
  a_call_exits: assert property (@(posedge mclk_in) disable iff (!rstn_in)
    state == VMS_NONROOT && req_valid && req_in.cmd == VMS_CMD_MONITOR_CALL
    |=> redir_out.valid) else $error("monitor call did not exit");
  a_leave_outside: assert property (@(posedge mclk_in) disable iff (!rstn_in)
    state == VMS_ROOT && req_valid && req_in.cmd == VMS_CMD_LEAVE
    |=> state == VMS_OUTSIDE) else $error("leave failed");
  a_enable_fault: assert property (@(posedge mclk_in) disable iff (!rstn_in)
    state == VMS_OUTSIDE && req_valid && req_in.cmd == VMS_CMD_ENTER && !virt_en
    |=> ud_fault_out && state == VMS_OUTSIDE) else $error("missing fault");
  a_init_root_held: assert property (@(posedge mclk_in) disable iff (!rstn_in)
    state == VMS_ROOT && soft_init_in |=> init_held_out && !redir_out.valid)
    else $error("init not held in root");
  a_init_guest_exit: assert property (@(posedge mclk_in) disable iff (!rstn_in)
    state == VMS_NONROOT && soft_init_in |=> redir_out.cause == VMS_EXIT_INIT)
    else $error("init did not exit guest");
  a_priv_ignored: assert property (@(posedge mclk_in) disable iff (!rstn_in)
    state == VMS_NONROOT && req_valid && req_in.trap_sel && req_in.priv == '0
    |=> state == VMS_ROOT) else $error("ring zero escaped trap");
  a_reset_outside: assert property (@(posedge mclk_in)
    !rstn_in |=> state == VMS_OUTSIDE && !in_virt_op_out)
    else $error("reset not outside");
  a_visible_same: assert property (@(posedge mclk_in) disable iff (!rstn_in)
    state != VMS_OUTSIDE |-> in_virt_op_out && virt_instr_en_out && ctrl_restrict_out)
    else $error("root extras missing");

endmodule

`default_nettype wire

// ==== test/vms_testbench.sv ====
// Self-checking bench for vms_sequencer: random and directed state traffic.
// Assumes vms_pkg is compiled first; expectations come from bench functions.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import vms_pkg::*;
  logic                  mclk_in = 1'b0;
  logic                  rstn_in = 1'b0;
  vms_req_t              req_in = '0;
  logic [VMS_CTRL_W-1:0] ctrl_reg_in = '0;
  logic [VMS_ADDR_W-1:0] entry_point_in = '0;
  logic                  exit_event_in = 1'b0;
  logic                  soft_init_in = 1'b0;
  vms_state_t            state_out;
  vms_redir_t            redir_out;
  logic                  vi_en, cr_rs, in_vo, ud, held, dlv, g_rs;
  logic [VMS_CTX_W-1:0]  g_ctx;
  integer seed = 32'h9f9af866;
  int miscompares = 0, n_tests = 0, cycles = 0, i;
  vms_state_t st;
  logic [VMS_ADDR_W-1:0] tgt;
  logic [VMS_CTX_W-1:0]  ctx;
  localparam logic [31:0] EN = 32'h0000_2000;
  vms_sequencer u_dut (.mclk_in(mclk_in), .rstn_in(rstn_in), .req_in(req_in),
    .ctrl_reg_in(ctrl_reg_in), .entry_point_in(entry_point_in), .exit_event_in(exit_event_in),
    .soft_init_in(soft_init_in), .state_out(state_out), .virt_instr_en_out(vi_en),
    .ctrl_restrict_out(cr_rs), .in_virt_op_out(in_vo), .ud_fault_out(ud), .init_held_out(held),
    .init_deliver_out(dlv), .redir_out(redir_out), .guest_ctx_out(g_ctx),
    .guest_restrict_out(g_rs));
  // 250 MHz core clock
  always #2 mclk_in = ~mclk_in;
  // Hang guard, far above the few thousand cycles the run needs
  always @(posedge mclk_in) begin
    cycles++;
    if (cycles == 10000) begin
      miscompares++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("compares %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk_bit(string n, logic e, logic s);
    n_tests++;
    if (s !== e) begin
      miscompares++;
      $display("[FAIL] %s exp %b got %b", n, e, s);
    end
  endtask
  task automatic chk_w(string n, logic [63:0] e, logic [63:0] s);
    n_tests++;
    if (s !== e) begin
      miscompares++;
      $display("[FAIL] %s exp %h got %h", n, e, s);
    end
  endtask
  // Exit cause in priority order: init, event, call, trapped instruction
  function automatic logic [2:0] cause_of(vms_state_t s, vms_req_t r, logic ev, logic si);
    if (s != VMS_NONROOT) return VMS_EXIT_NONE;
    if (si) return VMS_EXIT_INIT;
    if (ev) return VMS_EXIT_EVENT;
    if (r.valid && r.cmd == VMS_CMD_MONITOR_CALL) return VMS_EXIT_CALL;
    if (r.valid && r.trap_sel) return VMS_EXIT_TRAP;
    return VMS_EXIT_NONE;
  endfunction
  function automatic vms_state_t next_of(vms_state_t s, vms_req_t r, logic en, logic [2:0] c);
    if (s == VMS_NONROOT) return (c != VMS_EXIT_NONE) ? VMS_ROOT : VMS_NONROOT;
    if (!r.valid) return s;
    if (s == VMS_OUTSIDE) return (r.cmd == VMS_CMD_ENTER && en) ? VMS_ROOT : VMS_OUTSIDE;
    if (r.cmd == VMS_CMD_LEAVE) return VMS_OUTSIDE;
    if (r.cmd == VMS_CMD_FIRST_ENTRY || r.cmd == VMS_CMD_REPEAT_ENTRY) return VMS_NONROOT;
    return VMS_ROOT;
  endfunction
  function automatic vms_req_t mk(vms_cmd_t c, logic [15:0] x, logic t);
    return {1'b1, c, x, t, 2'h0};
  endfunction
  // One request cycle: drive after the edge, check after the next edge
  task automatic step(vms_req_t r, logic [31:0] c, logic ev, logic si);
    logic [2:0] cs;
    vms_state_t ns;
    logic [63:0] ep;
    ep = {$random(seed), $random(seed)};
    req_in = r; ctrl_reg_in = c; exit_event_in = ev; soft_init_in = si; entry_point_in = ep;
    cs = cause_of(st, r, ev, si);
    ns = next_of(st, r, c[VMS_ENABLE_BIT], cs);
    @(posedge mclk_in); #1;
    if (cs != VMS_EXIT_NONE) tgt = ep;
    if (st == VMS_ROOT && ns == VMS_NONROOT) ctx = r.ctx;
    chk_w("state", 64'(ns), 64'(state_out));
    chk_bit("ud_fault", st == VMS_OUTSIDE && r.valid && r.cmd == VMS_CMD_ENTER && !c[13], ud);
    chk_bit("in_virt_op", ns != VMS_OUTSIDE, in_vo);
    chk_bit("virt_instr_en", ns != VMS_OUTSIDE, vi_en);
    chk_bit("ctrl_restrict", ns != VMS_OUTSIDE, cr_rs);
    chk_bit("guest_restrict", ns == VMS_NONROOT, g_rs);
    chk_bit("init_held", st == VMS_ROOT && si, held);
    chk_bit("init_deliver", st == VMS_OUTSIDE && si, dlv);
    chk_bit("redir_valid", cs != VMS_EXIT_NONE, redir_out.valid);
    chk_w("redir_target", tgt, redir_out.target);
    if (cs != VMS_EXIT_NONE) chk_w("redir_cause", 64'(cs), 64'(redir_out.cause));
    chk_w("guest_ctx", 64'(ctx), 64'(g_ctx));
    st = ns;
  endtask
  task automatic do_reset(int n);
    rstn_in = 1'b0;
    req_in = '0; soft_init_in = 1'b0; exit_event_in = 1'b0;
    repeat (n) @(posedge mclk_in);
    #1 rstn_in = 1'b1;
    st = VMS_OUTSIDE; tgt = '0; ctx = '0;
    chk_w("reset_state", 64'(VMS_OUTSIDE), 64'(state_out));
    chk_w("reset_ctx", 64'h0, 64'(g_ctx));
    chk_bit("reset_redir", 1'b0, redir_out.valid);
  endtask
  // Random traffic with rare events, requests never valid, and a mostly set enable bit
  task automatic rand_run(int n);
    vms_req_t r;
    for (i = 0; i < n; i++) begin
      r = {$random(seed)} % 2;
      r = {r.valid, vms_cmd_t'({$random(seed)} % 6), 16'($random(seed)), 3'($random(seed))};
      step(r, $random(seed) | (({$random(seed)} % 4 != 0) ? EN : 32'h0),
           ({$random(seed)} % 8) == 0, ({$random(seed)} % 8) == 0);
    end
    $display("random run of %0d cycles done", n);
  endtask
  initial begin
    do_reset(16);
    // Directed walk through every command, cause and refusal
    step(mk(VMS_CMD_ENTER, 16'h0, 1'b0), 32'h0, 1'b0, 1'b0);
    step(mk(VMS_CMD_ENTER, 16'h0, 1'b0), EN, 1'b0, 1'b1);
    step('0, EN, 1'b0, 1'b1);
    step(mk(VMS_CMD_FIRST_ENTRY, 16'h0005, 1'b0), EN, 1'b0, 1'b0);
    step(mk(VMS_CMD_ENTER, 16'h0, 1'b0), EN, 1'b0, 1'b0);
    step(mk(VMS_CMD_MONITOR_CALL, 16'h0, 1'b0), EN, 1'b0, 1'b0);
    step(mk(VMS_CMD_REPEAT_ENTRY, 16'hFFFF, 1'b0), EN, 1'b0, 1'b0);
    step(mk(VMS_CMD_LEAVE, 16'h0, 1'b1), EN, 1'b1, 1'b0);
    step(mk(VMS_CMD_REPEAT_ENTRY, 16'h0009, 1'b0), EN, 1'b0, 1'b0);
    step(mk(VMS_CMD_NONE, 16'h0, 1'b1), EN, 1'b0, 1'b0);
    step(mk(VMS_CMD_FIRST_ENTRY, 16'h0003, 1'b0), EN, 1'b0, 1'b0);
    step(mk(VMS_CMD_MONITOR_CALL, 16'h0, 1'b1), EN, 1'b1, 1'b1);
    step(mk(VMS_CMD_LEAVE, 16'h0, 1'b0), EN, 1'b0, 1'b0);
    step('0, 32'h0, 1'b0, 1'b1);
    $display("directed walk done");
    rand_run(2000);
    do_reset(2);
    rand_run(500);
    end_of_test();
  end
endmodule
`default_nettype wire
